// ===== psl_port.v
// Overview of operation
// - Thirty-two pins, numbered 0 to 31, each with its own setup register.
// - Setup holds direction, drive, pulls, sensing, buffer disconnect, analog input.
// - Level-watch field picks high-level or low-level sensing per pin.
// - Pin at its watched level raises its own separate match signal.
// - Default source: all per-pin matches combine into one detect output.
// - Sense and detect logic work in running and off power states.
// - Enabling sense on a pin already at level raises match at once.
// - Port group event issues only if detect was low beforehand.
// - Rising pin match sets the latch bit of the same index.
// - Clearing a latch bit fails while that pin's match is high.
// - Latch bits clear only by writing one; falling match leaves them.
// - Latched flag high while any latch bit set, low after all cleared.
// - Bits left set after a clear give the latched flag a fresh edge.
// - Latch register is readable anytime, reporting past matches, whatever the source.
// - Source select picks combined matches or latched flag for detect output.
// - Disconnected input buffer hides pin from input register and sense logic.
// - Other peripherals may override pin output and direction, read inputs.
// - Setup registers are retained across low-power states.
// - Detect output feeds power controller wake and pin-event unit.
// - Source select register sits at offset 0x524.
// - Latch register sits at offset 0x520.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "psl_map.vh"

module psl_port (
	input wire core_clk_in,
	input wire sys_rst_in,
	input wire [31:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [31:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire [31:0] pad_in,
	output reg [31:0] pad_out,
	output reg [31:0] pad_oe_n_out,
	output reg [31:0] pull_up_en_out,
	output reg [31:0] pull_down_en_out,
	output reg [95:0] drive_out,
	output reg [31:0] analog_pin_input_out,
	input wire [31:0] periph_ovr_en_in,
	input wire [31:0] periph_out_in,
	input wire [31:0] periph_dir_in,
	output reg [31:0] periph_in_out,
	output reg [31:0] per_pin_match_out,
	output reg latched_match_flag_out,
	output reg port_detect_out,
	output reg port_event_out
);

	// ------------------------------------------------------------
	// Bus slave state
	// ------------------------------------------------------------
	reg aw_full;
	reg w_full;
	reg [11:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	wire wr_go;
	wire next_aw_full;
	wire next_w_full;
	wire next_bvalid;
	wire next_rvalid;
	wire [31:0] wmask;
	wire wr_setup;
	wire wr_map_ok;

	// ------------------------------------------------------------
	// Port state
	// ------------------------------------------------------------
	reg [31:0] out_val;
	reg match_mode;
	reg [31:0] latch_bits;
	reg [31:0] sync1;
	reg [31:0] sync2;
	reg [31:0] sync3;
	reg [31:0] pin_level;
	reg [31:0] set_dir;
	reg [31:0] set_disc;
	reg [31:0] set_ana;
	reg [63:0] set_pull;
	reg [95:0] set_drv;
	reg [63:0] set_sns;
	wire [1023:0] setup_flat;
	wire [31:0] match_now;
	wire [31:0] in_value;
	wire [31:0] clr_mask;
	wire latch_clr_wr;
	wire [31:0] next_latch;
	wire next_latched_match_flag;
	wire next_detect;
	reg [31:0] rd_word;
	reg rd_ok;
	wire wr_out;
	wire wr_mode;

	// ------------------------------------------------------------
	// Setup fields after reset
	// ------------------------------------------------------------
	// Input, buffer disconnected, sense off: a floating pin draws no
	// current and raises no match until software sets it up
	localparam [31:0] SETUP_RST = `PSL_SETUP_RST;
	localparam [0:0] RST_DIR = SETUP_RST[`PSL_F_DIR];
	localparam [0:0] RST_DISC = SETUP_RST[`PSL_F_DISC];
	localparam [0:0] RST_ANA = SETUP_RST[`PSL_F_ANA];
	localparam [1:0] RST_PULL = SETUP_RST[`PSL_F_PULL];
	localparam [2:0] RST_DRV = SETUP_RST[`PSL_F_DRV];
	localparam [1:0] RST_SNS = SETUP_RST[`PSL_F_SNS];

	assign wr_go = aw_full & w_full & ~s_axi_bvalid_out;
	assign next_aw_full = aw_full ? ~wr_go
		: (s_axi_awvalid_in & s_axi_awready_out);
	assign next_w_full = w_full ? ~wr_go
		: (s_axi_wvalid_in & s_axi_wready_out);
	assign next_bvalid = s_axi_bvalid_out ? ~s_axi_bready_in : wr_go;
	assign next_rvalid = s_axi_rvalid_out ? ~s_axi_rready_in
		: (s_axi_arvalid_in & s_axi_arready_out);
	assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
		{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign wr_setup = (wr_addr[11:7] == `PSL_SETUP_PAGE);
	assign wr_map_ok = wr_setup || (wr_addr == `PSL_OUT_OFS)
		|| (wr_addr == `PSL_IN_OFS) || (wr_addr == `PSL_LATCH_OFS)
		|| (wr_addr == `PSL_MODE_OFS);

	// ------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `PSL_RESP_OKAY;
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rresp_out <= `PSL_RESP_OKAY;
			s_axi_rdata_out <= 32'h00000000;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_awready_out <= ~next_aw_full;
			s_axi_wready_out <= ~next_w_full;
			s_axi_bvalid_out <= next_bvalid;
			s_axi_rvalid_out <= next_rvalid;
			s_axi_arready_out <= ~next_rvalid;
			if (s_axi_awvalid_in && s_axi_awready_out)
				wr_addr <= s_axi_awaddr_in[11:0];
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				wr_data <= s_axi_wdata_in;
				wr_strb <= s_axi_wstrb_in;
			end
			if (wr_go)
				s_axi_bresp_out <= wr_map_ok ? `PSL_RESP_OKAY
					: `PSL_RESP_SLVERR;
			if (s_axi_arvalid_in && s_axi_arready_out)
			begin
				s_axi_rdata_out <= rd_ok ? rd_word : 32'h00000000;
				s_axi_rresp_out <= rd_ok ? `PSL_RESP_OKAY
					: `PSL_RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	always @*
	begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr_in[11:7] == `PSL_SETUP_PAGE)
			rd_word = setup_flat[{s_axi_araddr_in[6:2], 5'h00} +: 32];
		else
			case (s_axi_araddr_in[11:0])
				`PSL_OUT_OFS: rd_word = out_val;
				`PSL_IN_OFS: rd_word = in_value;
				// Past matches stay visible, detect source regardless
				`PSL_LATCH_OFS: rd_word = latch_bits;
				`PSL_MODE_OFS: rd_word = {31'h00000000, match_mode};
				default: rd_ok = 1'b0;
			endcase
	end

	// ------------------------------------------------------------
	// Per-pin setup, input filter and match
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : g_pin
			wire hit;
			assign hit = wr_go && wr_setup && (wr_addr[6:2] == i);
			assign setup_flat[i*32 +: 32] = {14'h0000, set_sns[2*i +: 2],
				5'h00, set_drv[3*i +: 3], 3'h0, set_ana[i],
				set_pull[2*i +: 2], set_disc[i], set_dir[i]};
			// Buffer disconnected: no input value, sense blind
			assign in_value[i] = pin_level[i] & ~set_disc[i];
			// Watched level compared each cycle, so an already
			// matching pin fires as soon as sense is enabled
			assign match_now[i] = ~set_disc[i]
				& set_sns[2*i+`PSL_SNS_EN]
				& (pin_level[i] ^ set_sns[2*i+`PSL_SNS_LOW]);

			// Reset only by system reset, so contents survive
			// low-power states while the always-on clock runs
			always @(posedge core_clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					set_dir[i] <= RST_DIR;
					set_disc[i] <= RST_DISC;
					set_ana[i] <= RST_ANA;
					set_pull[2*i +: 2] <= RST_PULL;
					set_drv[3*i +: 3] <= RST_DRV;
					set_sns[2*i +: 2] <= RST_SNS;
				end
				else if (hit)
				begin
					if (wr_strb[0])
					begin
						set_dir[i] <= wr_data[`PSL_F_DIR];
						set_disc[i] <= wr_data[`PSL_F_DISC];
						set_ana[i] <= wr_data[`PSL_F_ANA];
						set_pull[2*i +: 2] <= wr_data[`PSL_F_PULL];
					end
					if (wr_strb[1])
						set_drv[3*i +: 3] <= wr_data[`PSL_F_DRV];
					if (wr_strb[2])
						set_sns[2*i +: 2] <= wr_data[`PSL_F_SNS];
				end
			end

			// Pin drivers; a peripheral override wins over software
			always @(posedge core_clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					pad_out[i] <= 1'b0;
					pad_oe_n_out[i] <= 1'b1;
					pull_up_en_out[i] <= 1'b0;
					pull_down_en_out[i] <= 1'b0;
					drive_out[3*i +: 3] <= 3'h0;
					analog_pin_input_out[i] <= 1'b0;
				end
				else
				begin
					pad_out[i] <= periph_ovr_en_in[i] ? periph_out_in[i]
						: out_val[i];
					pad_oe_n_out[i] <= periph_ovr_en_in[i]
						? ~periph_dir_in[i] : ~set_dir[i];
					pull_up_en_out[i] <=
						(set_pull[2*i +: 2] == `PSL_PULL_UP);
					pull_down_en_out[i] <=
						(set_pull[2*i +: 2] == `PSL_PULL_DOWN);
					drive_out[3*i +: 3] <= set_drv[3*i +: 3];
					analog_pin_input_out[i] <= set_ana[i];
				end
			end

			// Three stages against metastability; a new level counts
			// only once the second and third stages agree
			always @(posedge core_clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					sync1[i] <= 1'b0;
					sync2[i] <= 1'b0;
					sync3[i] <= 1'b0;
					pin_level[i] <= 1'b0;
				end
				else
				begin
					sync1[i] <= pad_in[i];
					sync2[i] <= sync1[i];
					sync3[i] <= sync2[i];
					if (sync2[i] == sync3[i])
						pin_level[i] <= sync3[i];
				end
			end

			// Set wins over clear; clear refused while match is high
			assign next_latch[i] = (match_now[i]
				& ~per_pin_match_out[i])
				| (latch_bits[i]
				& ~(clr_mask[i] & ~match_now[i]));

			always @(posedge core_clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					latch_bits[i] <= 1'b0;
					per_pin_match_out[i] <= 1'b0;
				end
				else
				begin
					latch_bits[i] <= next_latch[i];
					per_pin_match_out[i] <= match_now[i];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Latch and detect
	// ------------------------------------------------------------
	assign latch_clr_wr = wr_go && (wr_addr == `PSL_LATCH_OFS);
	assign clr_mask = latch_clr_wr ? (wr_data & wmask) : 32'h00000000;
	// One low cycle after any clear gives a fresh rising edge
	assign next_latched_match_flag = (|next_latch) & ~latch_clr_wr;
	assign next_detect = match_mode ? next_latched_match_flag
		: (|match_now);
	assign wr_out = wr_go && (wr_addr == `PSL_OUT_OFS);
	assign wr_mode = wr_go && (wr_addr == `PSL_MODE_OFS) && wr_strb[0];

	// ------------------------------------------------------------
	// Port registers
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			out_val <= `PSL_OUT_RST;
			match_mode <= `PSL_MODE_RST;
			periph_in_out <= 32'h00000000;
		end
		else
		begin
			periph_in_out <= in_value;
			if (wr_out)
				out_val <= (out_val & ~wmask) | (wr_data & wmask);
			if (wr_mode)
				match_mode <= wr_data[0];
		end
	end

	// ------------------------------------------------------------
	// Detect outputs
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			latched_match_flag_out <= 1'b0;
			port_detect_out <= 1'b0;
			port_event_out <= 1'b0;
		end
		else
		begin
			latched_match_flag_out <= next_latched_match_flag;
			// Single always-on clock domain keeps detect alive when off
			port_detect_out <= next_detect;
			port_event_out <= next_detect & ~port_detect_out;
		end
	end

endmodule // psl_port
`default_nettype wire

// ===== psl_map.vh
`ifndef PSL_MAP_VH
`define PSL_MAP_VH

// ------------------------------------------------------------
// Register offsets, low 12 address bits
// ------------------------------------------------------------
`define PSL_OUT_OFS 12'h504
`define PSL_IN_OFS 12'h510
`define PSL_LATCH_OFS 12'h520
`define PSL_MODE_OFS 12'h524
// Setup registers fill 0x700..0x77C, one word per pin
`define PSL_SETUP_PAGE 5'h0E

// ------------------------------------------------------------
// Setup register fields
// ------------------------------------------------------------
`define PSL_F_DIR 0
`define PSL_F_DISC 1
`define PSL_F_PULL 3:2
`define PSL_F_ANA 4
`define PSL_F_DRV 10:8
`define PSL_F_SNS 17:16
`define PSL_PULL_DOWN 2'h1
`define PSL_PULL_UP 2'h3
// Sense: upper bit enables, lower bit picks low level
`define PSL_SNS_EN 1
`define PSL_SNS_LOW 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PSL_SETUP_RST 32'h00000002
`define PSL_OUT_RST 32'h00000000
`define PSL_MODE_RST 1'h0

// ------------------------------------------------------------
// Bus answers
// ------------------------------------------------------------
`define PSL_RESP_OKAY 2'h0
`define PSL_RESP_SLVERR 2'h2

`endif

// ===== psl_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin wires seen by the port
// ----
module psl_pad_model (
	input wire logic [31:0] level_in,
	input wire logic [31:0] drive_in,
	input wire logic [31:0] oe_n_in,
	output logic [31:0] pad_level_out
);
	// A driven pin shows the port's value, else the outside level
	assign pad_level_out = (~oe_n_in & drive_in) | (oe_n_in & level_in);
endmodule // psl_pad_model
`default_nettype wire

// ===== psl_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psl_chk (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] pull_up_en_out,
	input wire logic [31:0] pull_down_en_out,
	input wire logic [31:0] per_pin_match_out,
	input wire logic latched_match_flag_out,
	input wire logic port_detect_out,
	input wire logic port_event_out
);
	wire any_m;
	assign any_m = |per_pin_match_out;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----
	// Checks
	// ----
	chk_evt_rise: assert property (
		$rose(port_detect_out) |-> ##[0:1] port_event_out)
		else $error("no event after detect rise");
	chk_evt_pulse: assert property (
		port_event_out |=> !port_event_out)
		else $error("event longer than one cycle");
	chk_flag_set: assert property (
		$rose(any_m) |-> ##[0:3] latched_match_flag_out)
		else $error("latched flag missed a match");
	chk_flag_fresh: assert property (
		$fell(latched_match_flag_out) && any_m
		|-> ##[1:2] latched_match_flag_out)
		else $error("no fresh latched edge");
	chk_det_source: assert property (
		port_detect_out |-> any_m || latched_match_flag_out
		|| $past(any_m) || $past(latched_match_flag_out))
		else $error("detect without a source");
	chk_pull_excl: assert property (
		(pull_up_en_out & pull_down_en_out) == 32'h0)
		else $error("both pulls on");
	chk_wr_answer: assert property (
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out && !s_axi_bvalid_out |-> ##2 s_axi_bvalid_out)
		else $error("write not answered");
	chk_rd_answer: assert property (
		s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read not answered");
	cover property (port_event_out);
	cover property ($fell(latched_match_flag_out) ##1 latched_match_flag_out);
	cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule // psl_chk
bind psl_port psl_chk u_chk (.core_clk_in, .sys_rst_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rvalid_out, .pull_up_en_out,
	.pull_down_en_out, .per_pin_match_out, .latched_match_flag_out,
	.port_detect_out, .port_event_out);
`default_nettype wire

// ===== pin_sense_latch_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sense_latch_detect_tb;
	logic core_clk_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in;
	logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, latched_match_flag_out;
	logic port_detect_out, port_event_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
	logic [3:0] s_axi_wstrb_in;
	logic [95:0] drive_out;
	logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in;
	logic [31:0] s_axi_rdata_out, pad_in, pad_out, pad_oe_n_out;
	logic [31:0] pull_up_en_out, pull_down_en_out, analog_pin_input_out;
	logic [31:0] periph_ovr_en_in, periph_out_in, periph_dir_in;
	logic [31:0] periph_in_out, per_pin_match_out;
	logic [31:0] lvl, sen, slo, dis, lat, em, r, lf;
	int err_count, cmp_count, cyc, evn, i;
	psl_port dut (.*);
	psl_pad_model pads (.level_in(lvl), .drive_in(pad_out),
		.oe_n_in(pad_oe_n_out), .pad_level_out(pad_in));
	// ----
	// Clock, watchdog, helpers
	// ----
	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (port_event_out === 1'b1)
			evn++;
		if (cyc == 30000)
		begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		s_axi_awaddr_in <= {20'h0, a};
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do
		begin
			@(posedge core_clk_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		resp = s_axi_bresp_out;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge core_clk_in);
		s_axi_araddr_in <= {20'h0, a};
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do
		begin
			@(posedge core_clk_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		r = s_axi_rdata_out;
		resp = s_axi_rresp_out;
	endtask
	task automatic cfg(input int n, input logic [1:0] s, input logic c);
		wr(12'h700 + 12'(4 * n), {14'h0, s, 14'h0, c, 1'b0});
		sen[n] = s[1];
		slo[n] = s[0];
		dis[n] = c;
	endtask
	// Pin path is three sync stages, a level register, then match and detect registers
	task automatic look();
		repeat (6) @(posedge core_clk_in);
		em = sen & ~dis & (lvl ^ slo);
		lat = lat | em;
		chk(per_pin_match_out, em);
		chk(periph_in_out, lvl & ~dis);
	endtask
	task automatic clr(input logic [31:0] m);
		wr(12'h520, m);
		lat = lat & ~(m & ~em);
	endtask
	// ----
	// Main sequence
	// ----
	initial
	begin
		{sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in} = 3'h4;
		{s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 3'h0;
		{s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = 96'h0;
		{periph_ovr_en_in, periph_out_in, periph_dir_in} = 96'h0;
		s_axi_wstrb_in = 4'hF;
		{lvl, sen, slo, lat} = 128'h0;
		dis = 32'hFFFFFFFF;
		lf = 32'h1D;
		repeat (5) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		chk(pad_oe_n_out, 32'hFFFFFFFF);
		for (i = 0; i < 32; i++)
		begin
			rd(12'h700 + 12'(4 * i));
			chk(r, 32'h2);
		end
		rd(12'h524);
		chk(r, 32'h0);
		wr(12'h600, 32'h0);
		chk(resp, 2'h2);
		lvl <= 32'h1;
		look();
		cfg(0, 2'h2, 1'b0);
		look();
		chk(port_detect_out, 1'b1);
		chk(evn, 1);
		lvl <= 32'h3;
		look();
		cfg(1, 2'h2, 1'b0);
		look();
		chk(evn, 1);
		clr(32'h3);
		rd(12'h520);
		chk(r, lat);
		lvl <= 32'h0;
		look();
		rd(12'h520);
		chk(r, lat);
		chk(port_detect_out, 1'b0);
		clr(32'h3);
		look();
		chk(latched_match_flag_out, 1'b0);
		cfg(2, 2'h2, 1'b1);
		wr(12'h524, 32'h1);
		lvl <= 32'h7;
		look();
		chk(port_detect_out, 1'b1);
		lvl <= 32'h1;
		look();
		clr(32'h3);
		look();
		rd(12'h520);
		chk(r, lat);
		chk(port_detect_out, 1'b1);
		{periph_ovr_en_in, periph_out_in, periph_dir_in} <= {3{32'h8}};
		lvl <= 32'hAA00;
		look();
		chk({pad_out[3], pad_oe_n_out[3]}, 2'h2);
		wr(12'h750, 32'h0000071F);
		wr(12'h754, 32'h00000006);
		wr(12'h504, 32'h00100001);
		s_axi_wstrb_in <= 4'h1;
		wr(12'h504, 32'h00000000);
		s_axi_wstrb_in <= 4'hF;
		wr(12'h510, 32'hFFFFFFFF);
		chk(resp, 2'h0);
		rd(12'h510);
		chk(r, lvl & ~dis);
		rd(12'h750);
		chk(r, 32'h0000071F);
		rd(12'h504);
		chk(r, 32'h00100000);
		chk(resp, 2'h0);
		rd(12'h524);
		chk(r, 32'h1);
		rd(12'h600);
		chk(r, 32'h0);
		chk(resp, 2'h2);
		chk(pull_up_en_out, 32'h00100000);
		chk(pull_down_en_out, 32'h00200000);
		chk(analog_pin_input_out, 32'h00100000);
		chk(drive_out[63:32], 32'h70000000);
		chk(drive_out[95:64] | drive_out[31:0], 32'h0);
		chk(pad_out, 32'h00100008);
		chk(pad_oe_n_out, 32'hFFEFFFF7);
		for (i = 8; i < 16; i++)
			cfg(i, {1'b1, i[0]}, 1'b0);
		for (i = 0; i < 20; i++)
		begin
			lf = lfsr(lf);
			lvl <= {16'h0, lf[15:8], 6'h0, lf[1:0]};
			look();
			rd(12'h520);
			chk(r, lat);
			chk(latched_match_flag_out, |lat);
			chk(port_detect_out, |lat);
			clr(lf & 32'hFF03);
		end
		stop_test();
	end
endmodule // pin_sense_latch_detect_tb
`default_nettype wire
